// *** core/deil_pkg.sv ***
package deil_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int SLOW_PERIOD_US = 250;
	localparam int FAST_PERIOD_US = 2;
	localparam int SLOW_CYCLES = CLK_HZ / 1000000 * SLOW_PERIOD_US;
	localparam int FAST_CYCLES = CLK_HZ / 1000000 * FAST_PERIOD_US;
	localparam int CAN_BAUD = 500000;
	localparam int CAN_CYCLES = CLK_HZ / CAN_BAUD;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_STAT = 6'h04;
	localparam logic [5:0] OFS_FUNC = 6'h08;
	localparam logic [5:0] OFS_OUTS = 6'h0c;
	localparam logic [5:0] OFS_IRQ = 6'h10;
	localparam logic [5:0] OFS_MASK = 6'h14;
	localparam logic [5:0] OFS_FAST = 6'h18;

	// ==========================================================
	// Control field positions
	localparam int CTRL_SW_EN = 0;
	localparam int CTRL_SW_EN_PERM = 1;
	localparam int CTRL_FAULT = 2;
	localparam int CTRL_FAULT_CLR = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Function register: per-input polarity, shared pin direction
	localparam int FUNC_POL_LSB = 0;
	localparam int FUNC_DIR_LSB = 8;
	localparam int FUNC_LIMIT_EN = 10;
	localparam logic [31:0] FUNC_RESET = 32'h0000_0000;

	// Interrupt bit positions
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_STO_DROP = 1;
	localparam int IRQ_POS_LIMIT = 2;
	localparam int IRQ_NEG_LIMIT = 3;
	localparam int IRQ_FAST_EDGE = 4;
	localparam int IRQ_W = 5;

	typedef struct packed {
		logic [3:0] in_lvl;
		logic [1:0] shared_in;
		logic hw_enable;
	} deil_slow_s;

	typedef enum logic [2:0] {
		DEIL_OFF = 3'b001,
		DEIL_READY = 3'b010,
		DEIL_FAULT = 3'b100
	} deil_state_e;

endpackage : deil_pkg

// *** core/deil_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - Power stage only while safe torque input high
// - Safe torque input open removes all power
// - Hardware enable active high enables stage
// - Hardware enable ignored without safe torque
// - Software enable ANDed, may be permanent
// - Hardware enable low keeps stage disabled
// - Enable and slow inputs sampled every 250us
// - Two fast inputs sampled every 2us
// - Digital outputs refreshed every 250us
// - Two shared pins are input or output
// - Input polarity set per assigned function
// - Inputs three, four give limit stops
// - Ready contact closed when ready, enable-independent
// - Fault opens contact and inhibits stage
// - Shared pin output drives software-written output bits
// - Field bus bit rate default 500 kbaud
module deil_top import deil_pkg::*; #(
	parameter int SLOW_DIV = SLOW_CYCLES,
	parameter int FAST_DIV = FAST_CYCLES,
	parameter int CAN_DIV = CAN_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	// Field pins
	input wire logic safe_torque_off_input,
	input wire logic hw_enable_in,
	input wire logic [1:0] fast_in,
	input wire logic [1:0] slow_in,
	input wire logic [1:0] shared_pin_in,
	output logic [1:0] shared_pin_out,
	output logic [1:0] shared_pin_oe,
	output logic ready_contact,
	output logic power_stage_en,
	output logic positive_limit_stop,
	output logic negative_limit_stop,
	output logic [1:0] fast_latched,
	output logic can_bit_tick,
	output logic irq
);

	// Dividers count in 16 bits, so longer periods cannot be served
	if (SLOW_DIV < 2 || FAST_DIV < 2 || CAN_DIV < 2 ||
		SLOW_DIV > 65536 || FAST_DIV > 65536 ||
		CAN_DIV > 65536) begin : g_bad_div
		$error("Divider values must lie between 2 and 65536");
	end

	// ==========================================================
	// Input synchronisers
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end else begin
			sync1_ff <= {safe_torque_off_input, hw_enable_in, fast_in,
				shared_pin_in};
			sync2_ff <= sync1_ff;
		end
	end
	logic sto_s;
	logic hwen_s;
	logic [1:0] fast_s;
	logic [1:0] shin_s;
	assign {sto_s, hwen_s, fast_s, shin_s} = sync2_ff;
	logic [1:0] slow_s_ff;
	logic [1:0] slow_s1_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slow_s1_ff <= 2'h0;
			slow_s_ff <= 2'h0;
		end else begin
			slow_s1_ff <= slow_in;
			slow_s_ff <= slow_s1_ff;
		end
	end

	// ==========================================================
	// Period dividers
	logic [15:0] slow_cnt_ff;
	logic [15:0] fast_cnt_ff;
	logic [15:0] can_cnt_ff;
	logic slow_tick;
	logic fast_tick;
	assign slow_tick = (slow_cnt_ff == 16'(SLOW_DIV - 1));
	assign fast_tick = (fast_cnt_ff == 16'(FAST_DIV - 1));
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slow_cnt_ff <= 16'h0000;
			fast_cnt_ff <= 16'h0000;
			can_cnt_ff <= 16'h0000;
			can_bit_tick <= 1'b0;
		end else begin
			slow_cnt_ff <= slow_tick ? 16'h0000 : slow_cnt_ff + 16'h0001;
			fast_cnt_ff <= fast_tick ? 16'h0000 : fast_cnt_ff + 16'h0001;
			can_bit_tick <= (can_cnt_ff == 16'(CAN_DIV - 1));
			can_cnt_ff <= (can_cnt_ff == 16'(CAN_DIV - 1)) ? 16'h0000 :
				can_cnt_ff + 16'h0001;
		end
	end

	// ==========================================================
	// Registers
	logic [31:0] ctrl_ff;
	logic [31:0] func_ff;
	logic [1:0] outs_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [IRQ_W-1:0] irq_evt;
	logic wr_ctrl;
	logic wr_irq;
	// Read data are registered, so a read waits one cycle for them
	logic rd_pend_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			rd_pend_ff <= 1'b0;
		else
			rd_pend_ff <= avs_read && !rd_pend_ff;
	end
	assign avs_waitrequest = avs_read && !rd_pend_ff;
	assign wr_ctrl = avs_write && avs_address == OFS_CTRL && avs_byteenable[0];
	assign wr_irq = avs_write && avs_address == OFS_IRQ && avs_byteenable[0];

	// Function map survives reset like a saved parameter set; the
	// working copy takes it only at the next reset release
	logic [31:0] func_shadow_ff = FUNC_RESET;
	always_ff @(posedge clk_sys) begin
		if (avs_write && avs_address == OFS_FUNC &&
			avs_byteenable[1:0] == 2'h3)
			func_shadow_ff <= {21'h0, avs_writedata[10:0]};
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RESET;
			outs_ff <= 2'h0;
			irq_mask_ff <= '0;
		end else if (avs_write) begin
			if (wr_ctrl)
				ctrl_ff <= {28'h0, 1'b0, avs_writedata[2:0]};
			else
				ctrl_ff[CTRL_FAULT_CLR] <= 1'b0;
			if (avs_address == OFS_OUTS && avs_byteenable[0])
				outs_ff <= avs_writedata[1:0];
			if (avs_address == OFS_MASK && avs_byteenable[0])
				irq_mask_ff <= avs_writedata[IRQ_W-1:0];
		end
	end
	// New assignment only takes effect after the next reset
	logic func_loaded_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			func_ff <= FUNC_RESET;
			func_loaded_ff <= 1'b0;
		end else if (!func_loaded_ff) begin
			func_ff <= func_shadow_ff;
			func_loaded_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Slow sampling at the 250 us boundary
	deil_slow_s slow_ff;
	logic [1:0] fast_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			slow_ff <= '0;
			fast_ff <= 2'h0;
		end else begin
			if (slow_tick) begin
				slow_ff.hw_enable <= hwen_s;
				// Polarity applied per function
				slow_ff.in_lvl <= {slow_s_ff, fast_s} ^
					func_ff[FUNC_POL_LSB +: 4];
				slow_ff.shared_in <= (shin_s ^ func_ff[FUNC_POL_LSB+4 +: 2]) &
					~func_ff[FUNC_DIR_LSB +: 2];
			end
			if (fast_tick)
				fast_ff <= fast_s ^ func_ff[FUNC_POL_LSB +: 2];
		end
	end
	assign fast_latched = fast_ff;
	assign positive_limit_stop = func_ff[FUNC_LIMIT_EN] & slow_ff.in_lvl[2];
	assign negative_limit_stop = func_ff[FUNC_LIMIT_EN] & slow_ff.in_lvl[3];

	// ==========================================================
	// Readiness and fault state
	deil_state_e state_ff;
	deil_state_e nxt_state;
	logic fault_req;
	assign fault_req = wr_ctrl && avs_writedata[CTRL_FAULT];
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DEIL_OFF: nxt_state = DEIL_READY;
			DEIL_READY: if (fault_req) nxt_state = DEIL_FAULT;
			DEIL_FAULT:
				if (wr_ctrl && avs_writedata[CTRL_FAULT_CLR] && !fault_req)
					nxt_state = DEIL_READY;
			default: nxt_state = DEIL_FAULT;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			state_ff <= DEIL_OFF;
		else
			state_ff <= nxt_state;
	end
	// Contact ignores enables on purpose
	assign ready_contact = (state_ff == DEIL_READY);

	// ==========================================================
	// Enable interlock; safe torque is a direct path, not sampled,
	// so power drops one cycle after the sync delay regardless of period
	logic sw_en;
	assign sw_en = ctrl_ff[CTRL_SW_EN] | ctrl_ff[CTRL_SW_EN_PERM];
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			power_stage_en <= 1'b0;
		else
			power_stage_en <= sto_s && slow_ff.hw_enable && sw_en &&
				(nxt_state == DEIL_READY);
	end

	// ==========================================================
	// Output refresh every 250 us
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shared_pin_out <= 2'h0;
			shared_pin_oe <= 2'h0;
		end else if (slow_tick) begin
			shared_pin_oe <= func_ff[FUNC_DIR_LSB +: 2];
			shared_pin_out <= outs_ff & func_ff[FUNC_DIR_LSB +: 2];
		end
	end

	// ==========================================================
	// Interrupts, write one to clear; set wins
	logic sto_d_ff;
	logic [1:0] fast_d_ff;
	logic [1:0] lim_d_ff;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sto_d_ff <= 1'b0;
			fast_d_ff <= 2'h0;
			lim_d_ff <= 2'h0;
		end else begin
			sto_d_ff <= sto_s;
			fast_d_ff <= fast_ff;
			lim_d_ff <= {negative_limit_stop, positive_limit_stop};
		end
	end
	assign irq_evt = {
		|(fast_ff & ~fast_d_ff),
		negative_limit_stop & ~lim_d_ff[1],
		positive_limit_stop & ~lim_d_ff[0],
		sto_d_ff & ~sto_s,
		(state_ff == DEIL_READY) && (nxt_state == DEIL_FAULT)};
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			irq_stat_ff <= '0;
		else
			irq_stat_ff <= (irq_stat_ff &
				~(wr_irq ? avs_writedata[IRQ_W-1:0] : '0)) | irq_evt;
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ==========================================================
	// Read path
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
			avs_response_err <= 1'b0;
		end else begin
			avs_response_err <= 1'b0;
			avs_readdata <= 32'h0;
			if (avs_read) begin
				case (avs_address)
					OFS_CTRL: avs_readdata <= ctrl_ff;
					OFS_STAT: avs_readdata <= {22'h0, shin_s, slow_ff.in_lvl,
						power_stage_en, ready_contact, slow_ff.hw_enable, sto_s};
					OFS_FUNC: avs_readdata <= func_shadow_ff;
					OFS_OUTS: avs_readdata <= {30'h0, outs_ff};
					OFS_IRQ: avs_readdata <= {27'h0, irq_stat_ff};
					OFS_MASK: avs_readdata <= {27'h0, irq_mask_ff};
					OFS_FAST: avs_readdata <= {30'h0, fast_ff};
					default: avs_response_err <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	a_sto_cuts_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sto_s |=> !power_stage_en) else $error("Power with STO low");
	a_sto_drop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(sto_s) |=> !power_stage_en) else $error("No cut");
	a_hwen_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!slow_ff.hw_enable |=> !power_stage_en) else $error("Hw en");
	a_sw_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sw_en |=> !power_stage_en) else $error("Sw en ignored");
	a_fault_inhibit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ready_contact |-> !power_stage_en) else $error("Inhibit");
	a_slow_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!slow_tick |=> $stable(slow_ff.hw_enable)) else $error("Sample");
	a_out_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!slow_tick |=> $stable(shared_pin_out)) else $error("Refresh");
	a_pin_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(shared_pin_out & ~shared_pin_oe) == 2'h0) else $error("Dir");
	a_fast_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!fast_tick |=> $stable(fast_ff)) else $error("Fast sample");

	// ==========================================================
	// Bus, state and interrupt checks
	a_wr_no_wait: assert property (@(posedge clk_sys)
		disable iff (!rst_n) avs_write |-> !avs_waitrequest)
		else $error("Write stalled");
	a_rd_one_wait: assert property (@(posedge clk_sys)
		disable iff (!rst_n) avs_waitrequest |=> !avs_waitrequest)
		else $error("Read stalled");
	a_err_zero_data: assert property (@(posedge clk_sys)
		disable iff (!rst_n) avs_response_err |-> avs_readdata == 32'h0)
		else $error("Error with data");
	a_fault_opens: assert property (@(posedge clk_sys)
		disable iff (!rst_n) state_ff == DEIL_READY && fault_req
		|=> !ready_contact) else $error("Contact stays closed");
	a_fault_holds: assert property (@(posedge clk_sys)
		disable iff (!rst_n) state_ff == DEIL_FAULT && !wr_ctrl
		|=> !ready_contact) else $error("Fault left alone");
	a_ready_up: assert property (@(posedge clk_sys)
		disable iff (!rst_n) state_ff == DEIL_OFF |=> ready_contact)
		else $error("Not ready after reset");
	a_off_no_power: assert property (@(posedge clk_sys)
		disable iff (!rst_n) state_ff == DEIL_OFF |-> !power_stage_en)
		else $error("Power while off");
	a_limit_gate: assert property (@(posedge clk_sys)
		disable iff (!rst_n) !func_ff[FUNC_LIMIT_EN]
		|-> !positive_limit_stop && !negative_limit_stop)
		else $error("Limit stop without function");
	a_in_hold: assert property (@(posedge clk_sys)
		disable iff (!rst_n) !slow_tick |=> $stable(slow_ff.in_lvl))
		else $error("Inputs moved off period");
	a_oe_hold: assert property (@(posedge clk_sys)
		disable iff (!rst_n) !slow_tick |=> $stable(shared_pin_oe))
		else $error("Direction moved off period");
	a_shin_masked: assert property (@(posedge clk_sys)
		disable iff (!rst_n)
		(slow_ff.shared_in & func_ff[FUNC_DIR_LSB +: 2]) == 2'h0)
		else $error("Output pin read as input");
	a_func_frozen: assert property (@(posedge clk_sys)
		disable iff (!rst_n) func_loaded_ff |=> $stable(func_ff))
		else $error("Function map moved");
	a_can_pulse: assert property (@(posedge clk_sys)
		disable iff (!rst_n) can_bit_tick |=> !can_bit_tick)
		else $error("Bit tick too long");
	a_fault_sets: assert property (@(posedge clk_sys)
		disable iff (!rst_n) irq_evt[IRQ_FAULT] |=> irq_stat_ff[IRQ_FAULT])
		else $error("Fault event lost");
	a_sto_irq: assert property (@(posedge clk_sys)
		disable iff (!rst_n) $fell(sto_s) |=> irq_stat_ff[IRQ_STO_DROP])
		else $error("Safe torque drop lost");
	a_stat_sticky: assert property (@(posedge clk_sys)
		disable iff (!rst_n) irq_stat_ff[IRQ_FAULT] && !wr_irq
		|=> irq_stat_ff[IRQ_FAULT]) else $error("Status not sticky");
	a_fast_irq: assert property (@(posedge clk_sys)
		disable iff (!rst_n) irq_evt[IRQ_FAST_EDGE]
		|=> irq_stat_ff[IRQ_FAST_EDGE]) else $error("Fast edge lost");
	a_pos_irq: assert property (@(posedge clk_sys)
		disable iff (!rst_n) $rose(positive_limit_stop)
		|=> irq_stat_ff[IRQ_POS_LIMIT]) else $error("Limit event lost");
	a_neg_irq: assert property (@(posedge clk_sys)
		disable iff (!rst_n) $rose(negative_limit_stop)
		|=> irq_stat_ff[IRQ_NEG_LIMIT]) else $error("Limit event lost");
	c_power_on: cover property (@(posedge clk_sys) $rose(power_stage_en));
	c_fault: cover property (@(posedge clk_sys) $fell(ready_contact));
	c_irq: cover property (@(posedge clk_sys) $rose(irq));
	c_read_wait: cover property (@(posedge clk_sys) avs_waitrequest);
	c_fast_edge: cover property (@(posedge clk_sys) irq_evt[IRQ_FAST_EDGE]);

endmodule : deil_top

// *** tb/deil_plc_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Machine controller side of the field pins
module deil_plc_model (
	// Clock
	input wire logic clk_sys,
	// Levels the bench asks for: safe_torque_off_input, hardware enable, slow inputs
	input wire logic [3:0] want,
	// Device drive of the shared pins
	input wire logic [1:0] oe,
	input wire logic [1:0] dev_out,
	// Field pins
	output logic sto,
	output logic hw_en,
	output logic [1:0] slow,
	output logic [1:0] shared_in
);
	initial begin
		sto = 1'b0;
		hw_en = 1'b0;
		slow = 2'b00;
	end
	// Changes only after a clock edge, like an output scan
	always @(posedge clk_sys) begin
		sto <= want[0];
		hw_en <= want[1];
		slow <= want[3:2];
	end
	// Controller keeps its own side low, so a driven pin reads back
	assign shared_in = oe & dev_out;
endmodule : deil_plc_model

// *** tb/drive_enable_interlock_io_test.sv ***
`timescale 1ns/1ps
module drive_enable_interlock_io_test import deil_pkg::*;;
	logic clk_sys, rst_n, rd_s, wr_s, err, wreq, rdy, pw, irq, can, de;
	logic sto, hw, pls, nls;
	logic [5:0] adr;
	logic [31:0] wd, rdd, d;
	logic [1:0] sl, shi, sho, oe, fl, fin;
	logic [3:0] want;
	int errors, n_compared;
	deil_top #(.SLOW_DIV(50), .FAST_DIV(4), .CAN_DIV(CAN_CYCLES)) uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
		.avs_byteenable(4'hf), .avs_readdata(rdd),
		.avs_waitrequest(wreq), .avs_response_err(err),
		.safe_torque_off_input(sto), .hw_enable_in(hw), .fast_in(fin),
		.slow_in(sl), .shared_pin_in(shi), .shared_pin_out(sho),
		.shared_pin_oe(oe), .ready_contact(rdy), .power_stage_en(pw),
		.positive_limit_stop(pls), .negative_limit_stop(nls),
		.fast_latched(fl), .can_bit_tick(can), .irq(irq));
	deil_plc_model plc (.clk_sys(clk_sys), .want(want), .oe(oe),
		.dev_out(sho), .sto(sto), .hw_en(hw), .slow(sl), .shared_in(shi));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// ==========================================
	// Bus cycles: hold until waitrequest seen low, answer taken there
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [31:0] v);
		@(posedge clk_sys);
		adr <= a;
		wd <= v;
		if (w) wr_s <= 1'b1;
		else rd_s <= 1'b1;
		do @(posedge clk_sys); while (wreq !== 1'b0);
		d = rdd;
		de = err;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask : acc
	task automatic rd(input logic [5:0] a);
		acc(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic wait_pw(input logic v);
		for (int i = 0; i < 200 && pw !== v; i++) @(posedge clk_sys);
	endtask : wait_pw
	// ==========================================
	// Scenarios
	task automatic t_enable();
		chk(rdy, 1'b1);
		chk(pw, 1'b0);
		want <= 4'h3;
		acc(1'b1, OFS_CTRL, 32'h0000_0001);
		wait_pw(1'b1);
		chk(pw, 1'b1);
		rd(OFS_STAT);
		chk(d[3:0], 4'hf);
		want <= 4'h1;
		wait_pw(1'b0);
		chk(pw, 1'b0);
		want <= 4'h3;
		acc(1'b1, OFS_CTRL, 32'h0000_0000);
		repeat (150) @(posedge clk_sys);
		chk(pw, 1'b0);
		acc(1'b1, OFS_CTRL, 32'h0000_0002);
		wait_pw(1'b1);
		chk(pw, 1'b1);
	endtask : t_enable
	task automatic t_sto();
		want <= 4'h2;
		repeat (5) @(posedge clk_sys);
		chk(pw, 1'b0);
		repeat (120) @(posedge clk_sys);
		chk(pw, 1'b0);
		want <= 4'h3;
		wait_pw(1'b1);
		chk(pw, 1'b1);
	endtask : t_sto
	task automatic t_fault();
		acc(1'b1, OFS_CTRL, 32'h0000_0006);
		repeat (3) @(posedge clk_sys);
		chk(rdy, 1'b0);
		repeat (120) @(posedge clk_sys);
		chk(pw, 1'b0);
		chk(irq, 1'b0);
		rd(OFS_IRQ);
		chk(d[1:0], 2'b11);
		acc(1'b1, OFS_MASK, 32'h0000_0001);
		@(negedge clk_sys);
		chk(irq, 1'b1);
		acc(1'b1, OFS_CTRL, 32'h0000_000a);
		repeat (3) @(posedge clk_sys);
		chk(rdy, 1'b1);
		wait_pw(1'b1);
		chk(pw, 1'b1);
		acc(1'b1, OFS_IRQ, 32'h0000_0003);
		@(negedge clk_sys);
		chk(irq, 1'b0);
		rd(6'h3c);
		chk(de, 1'b1);
		chk(d, 32'h0000_0000);
	endtask : t_fault
	task automatic t_fast();
		fin <= 2'b01;
		repeat (8) @(posedge clk_sys);
		chk(fl, 2'b01);
		rd(OFS_FAST);
		chk(d[1:0], 2'b01);
		rd(OFS_IRQ);
		chk(d[IRQ_FAST_EDGE], 1'b1);
		fin <= 2'b00;
		repeat (8) @(posedge clk_sys);
		chk(fl, 2'b00);
	endtask : t_fast
	// New function map only after save and reset, reset in mid-run
	task automatic t_func();
		acc(1'b1, OFS_FUNC, 32'h0000_0504);
		acc(1'b1, OFS_OUTS, 32'h0000_0001);
		repeat (60) @(posedge clk_sys);
		chk(oe, 2'b00);
		chk(pls, 1'b0);
		rd(OFS_FUNC);
		chk(d, 32'h0000_0504);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(rdy, 1'b1);
		chk(pw, 1'b0);
		acc(1'b1, OFS_OUTS, 32'h0000_0001);
		repeat (60) @(posedge clk_sys);
		chk(oe, 2'b01);
		chk(sho, 2'b01);
		chk(pls, 1'b1);
		chk(nls, 1'b0);
		want <= 4'h7;
		repeat (60) @(posedge clk_sys);
		chk(pls, 1'b0);
		acc(1'b1, OFS_OUTS, 32'h0000_0000);
		repeat (60) @(posedge clk_sys);
		chk(sho, 2'b00);
	endtask : t_func
	task automatic t_can();
		int n;
		n = 0;
		while (can !== 1'b1 && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (can !== 1'b1 && n < 100);
		chk(n, CAN_CYCLES);
	endtask : t_can
	task automatic results();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	initial begin
		rst_n = 1'b0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		adr = 6'h00;
		wd = 32'h0000_0000;
		want = 4'h0;
		fin = 2'b00;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_enable();
		t_sto();
		t_fault();
		t_fast();
		t_func();
		t_can();
		results();
	end
	// Whole run is under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		results();
	end
endmodule : drive_enable_interlock_io_test
